/* File: subsys_ctrl_pkg.sv */
`default_nettype none
package subsys_ctrl_pkg;

  // management addressing
  localparam logic [4:0] MMD_SUBSYSTEM = 5'h1e;
  localparam logic [4:0] C22_ADDR_POINTER = 5'h10;
  localparam logic [4:0] C22_ADDR_DATA = 5'h11;

  // subsystem register offsets
  localparam logic [15:0] ADDR_SOFT_RESET = 16'hff0c;
  localparam logic [15:0] ADDR_RESAMPLE_EN = 16'hff0d;
  localparam logic [15:0] ADDR_CLOCK_SELECT = 16'hff1f;

  // reset values
  localparam logic [15:0] RESET_SOFT_RESET = 16'h0000;
  localparam logic [15:0] RESET_RESAMPLE_EN = 16'h0000;
  localparam logic [15:0] RESET_CLOCK_SELECT = 16'h0000;
  localparam logic [15:0] RESET_POINTER = 16'h0000;

  // field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int RESAMPLE_EN_BIT = 0;
  localparam int CLK_RCVR_125_BIT = 5;
  localparam int CLK_FREE_125_BIT = 4;
  localparam int CLK_HRT_RCVR_BIT = 2;
  localparam int CLK_HRT_FREE_BIT = 1;
  localparam int CLK_REF_25_BIT = 0;
  localparam int CLOCK_SELECT_W = 6;

  // timing: subsystem reset hold time
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SOFT_RESET_HOLD_NS = 80;
  localparam int SOFT_RESET_HOLD_CYCLES = (SOFT_RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // register decode result
  typedef enum logic [1:0]
  {
    SEL_NONE = 2'h0,
    SEL_SOFT_RESET = 2'h1,
    SEL_RESAMPLE_EN = 2'h2,
    SEL_CLOCK_SELECT = 2'h3
  } reg_sel_t;

  // soft reset sequencer states
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_HOLD = 4'h2,
    ST_SAMPLE = 4'h4,
    ST_LOAD = 4'h8
  } seq_state_t;

endpackage : subsys_ctrl_pkg

`default_nettype wire

/* File: subsystem_reset_clock_out_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

module subsystem_reset_clock_out_ctrl #(
  parameter int CFG_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // management register port from the frame decoder
  input wire logic mgmt_c22,
  input wire logic [4:0] mgmt_dev_addr,
  input wire logic [15:0] mgmt_reg_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // hardware configuration pins
  input wire logic [CFG_W-1:0] cfg_pins,
  output logic [CFG_W-1:0] cfg_value,
  output logic cfg_load,
  // subsystem reset towards the rest of the chip
  output logic subsys_rst_n,
  // source enables for the aux clock output pin mux
  output logic out_recovered_125m_enable,
  output logic out_free_125m_enable,
  output logic out_recovered_heartbeat_enable,
  output logic out_free_heartbeat_enable,
  output logic out_reference_25m_enable
);

  // whole block state in one record
  typedef struct packed {
    subsys_ctrl_pkg::seq_state_t st;
    logic soft_reset;
    logic resample_en;
    logic [subsys_ctrl_pkg::CLOCK_SELECT_W-1:0] clk_sel;
    logic [7:0] cnt;
    logic [15:0] pointer;
    logic [CFG_W-1:0] cfg_store;
    logic boot_done;
    logic cfg_load;
    logic subsys_rst_n;
    logic [15:0] rdata;
    logic rvalid;
  } state_t;

  state_t state_reg; // registered state
  state_t state_next; // next state

  // maps an access to a subsystem register; used for reads and writes
  function automatic subsys_ctrl_pkg::reg_sel_t decode(input logic c22, input logic [4:0] dev,
    input logic [15:0] addr, input logic [15:0] ptr);
    logic [15:0] target;
    target = addr;
    decode = subsys_ctrl_pkg::SEL_NONE;
    if (c22)
      target = (addr[4:0] == subsys_ctrl_pkg::C22_ADDR_DATA) ? ptr : 16'hffff;
    if (c22 || dev == subsys_ctrl_pkg::MMD_SUBSYSTEM)
    begin
      unique case (target)
        subsys_ctrl_pkg::ADDR_SOFT_RESET: decode = subsys_ctrl_pkg::SEL_SOFT_RESET;
        subsys_ctrl_pkg::ADDR_RESAMPLE_EN: decode = subsys_ctrl_pkg::SEL_RESAMPLE_EN;
        subsys_ctrl_pkg::ADDR_CLOCK_SELECT: decode = subsys_ctrl_pkg::SEL_CLOCK_SELECT;
        default: decode = subsys_ctrl_pkg::SEL_NONE;
      endcase
    end
  endfunction : decode

  localparam logic [7:0] HOLD_LAST = 8'(subsys_ctrl_pkg::SOFT_RESET_HOLD_CYCLES - 1);

  // next-state logic: register access, boot capture and soft reset sequence
  always_comb
  begin
    subsys_ctrl_pkg::reg_sel_t wsel;
    subsys_ctrl_pkg::reg_sel_t rsel;
    wsel = decode(mgmt_c22, mgmt_dev_addr, mgmt_reg_addr, state_reg.pointer);
    rsel = decode(mgmt_c22, mgmt_dev_addr, mgmt_reg_addr, state_reg.pointer);
    state_next = state_reg;
    state_next.cfg_load = 1'b0; // one-cycle pulse
    state_next.rvalid = 1'b0;

    // straps caught on the first edge after hardware reset release
    if (!state_reg.boot_done)
    begin
      state_next.boot_done = 1'b1;
      state_next.cfg_store = cfg_pins;
      state_next.cfg_load = 1'b1;
    end

    // register writes
    if (mgmt_wr)
    begin
      if (mgmt_c22 && mgmt_reg_addr[4:0] == subsys_ctrl_pkg::C22_ADDR_POINTER)
        state_next.pointer = mgmt_wdata;
      unique case (wsel)
        subsys_ctrl_pkg::SEL_SOFT_RESET:
        begin
          // a second request during a running sequence is absorbed by it
          if (mgmt_wdata[subsys_ctrl_pkg::SOFT_RESET_BIT] && state_reg.st == subsys_ctrl_pkg::ST_IDLE)
          begin
            state_next.soft_reset = 1'b1;
            state_next.st = subsys_ctrl_pkg::ST_HOLD;
            state_next.cnt = HOLD_LAST;
            state_next.subsys_rst_n = 1'b0;
          end
        end
        subsys_ctrl_pkg::SEL_RESAMPLE_EN:
          state_next.resample_en = mgmt_wdata[subsys_ctrl_pkg::RESAMPLE_EN_BIT];
        subsys_ctrl_pkg::SEL_CLOCK_SELECT:
          state_next.clk_sel = mgmt_wdata[subsys_ctrl_pkg::CLOCK_SELECT_W-1:0];
        default:
          state_next.clk_sel = state_reg.clk_sel; // unmapped write is dropped
      endcase
    end

    // register reads, answered one cycle later; unmapped reads return zero
    if (mgmt_rd)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata = 16'h0000;
      if (mgmt_c22 && mgmt_reg_addr[4:0] == subsys_ctrl_pkg::C22_ADDR_POINTER)
        state_next.rdata = state_reg.pointer;
      unique case (rsel)
        subsys_ctrl_pkg::SEL_SOFT_RESET:
          state_next.rdata[subsys_ctrl_pkg::SOFT_RESET_BIT] = state_reg.soft_reset;
        subsys_ctrl_pkg::SEL_RESAMPLE_EN:
          state_next.rdata[subsys_ctrl_pkg::RESAMPLE_EN_BIT] = state_reg.resample_en;
        subsys_ctrl_pkg::SEL_CLOCK_SELECT:
          state_next.rdata[subsys_ctrl_pkg::CLOCK_SELECT_W-1:0] = state_reg.clk_sel;
        default:
          state_next.rdata = state_next.rdata;
      endcase
    end

    // soft reset sequencer
    unique case (state_reg.st)
      subsys_ctrl_pkg::ST_IDLE:
        state_next.cnt = state_next.cnt;
      subsys_ctrl_pkg::ST_HOLD:
      begin
        state_next.cnt = state_reg.cnt - 8'h01;
        if (state_reg.cnt == 8'h00)
          state_next.st = state_reg.resample_en ? subsys_ctrl_pkg::ST_SAMPLE
                                                : subsys_ctrl_pkg::ST_LOAD;
      end
      subsys_ctrl_pkg::ST_SAMPLE:
      begin
        state_next.cfg_store = cfg_pins;
        state_next.st = subsys_ctrl_pkg::ST_LOAD;
      end
      subsys_ctrl_pkg::ST_LOAD:
      begin
        // stored settings go back to the management registers
        state_next.cfg_load = 1'b1;
        state_next.subsys_rst_n = 1'b1;
        state_next.soft_reset = 1'b0;
        state_next.st = subsys_ctrl_pkg::ST_IDLE;
      end
      default:
        state_next.st = subsys_ctrl_pkg::ST_IDLE; // a broken one-hot code falls back to idle
    endcase
  end

  // state register; synchronous active-low reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg.st <= subsys_ctrl_pkg::ST_IDLE;
      state_reg.soft_reset <= subsys_ctrl_pkg::RESET_SOFT_RESET[subsys_ctrl_pkg::SOFT_RESET_BIT];
      state_reg.resample_en <= subsys_ctrl_pkg::RESET_RESAMPLE_EN[subsys_ctrl_pkg::RESAMPLE_EN_BIT];
      state_reg.clk_sel <= subsys_ctrl_pkg::RESET_CLOCK_SELECT[subsys_ctrl_pkg::CLOCK_SELECT_W-1:0];
      state_reg.cnt <= 8'h00;
      state_reg.pointer <= subsys_ctrl_pkg::RESET_POINTER;
      state_reg.cfg_store <= '0;
      state_reg.boot_done <= 1'b0;
      state_reg.cfg_load <= 1'b0;
      state_reg.subsys_rst_n <= 1'b0; // subsystem held while the chip is held
      state_reg.rdata <= 16'h0000;
      state_reg.rvalid <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  // outputs straight from the state flops
  assign mgmt_rdata = state_reg.rdata;
  assign mgmt_rvalid = state_reg.rvalid;
  assign cfg_value = state_reg.cfg_store;
  assign cfg_load = state_reg.cfg_load;
  assign subsys_rst_n = state_reg.subsys_rst_n;
  // more than one enable set leaves the pin mux undefined
  assign out_recovered_125m_enable = state_reg.clk_sel[subsys_ctrl_pkg::CLK_RCVR_125_BIT];
  assign out_free_125m_enable = state_reg.clk_sel[subsys_ctrl_pkg::CLK_FREE_125_BIT];
  assign out_recovered_heartbeat_enable = state_reg.clk_sel[subsys_ctrl_pkg::CLK_HRT_RCVR_BIT];
  assign out_free_heartbeat_enable = state_reg.clk_sel[subsys_ctrl_pkg::CLK_HRT_FREE_BIT];
  assign out_reference_25m_enable = state_reg.clk_sel[subsys_ctrl_pkg::CLK_REF_25_BIT];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wire mmd_wr = mgmt_wr && !mgmt_c22 && mgmt_dev_addr == subsys_ctrl_pkg::MMD_SUBSYSTEM;

  a_soft_reset_start: assert property (mmd_wr && mgmt_reg_addr == subsys_ctrl_pkg::ADDR_SOFT_RESET
    && mgmt_wdata[0] && state_reg.st == subsys_ctrl_pkg::ST_IDLE |=> !subsys_rst_n && state_reg.soft_reset)
    else $error("soft reset write did not start sequence");
  a_resample_path: assert property (state_reg.st == subsys_ctrl_pkg::ST_SAMPLE
    |=> cfg_value == $past(cfg_pins) ##1 cfg_load)
    else $error("resample did not capture pins");
  a_reload_path: assert property (state_reg.st == subsys_ctrl_pkg::ST_HOLD && state_reg.cnt == 8'h00
    && !state_reg.resample_en |=> $stable(cfg_value) ##1 cfg_load && $stable(cfg_value))
    else $error("reload path changed stored pins");
  a_clock_sel_write: assert property (mmd_wr && mgmt_reg_addr == subsys_ctrl_pkg::ADDR_CLOCK_SELECT
    |=> out_recovered_125m_enable == $past(mgmt_wdata[5]) && out_reference_25m_enable == $past(mgmt_wdata[0])
    && out_free_125m_enable == $past(mgmt_wdata[4]))
    else $error("clock enable does not follow write");
  a_heartbeat_sel: assert property (mmd_wr && mgmt_reg_addr == subsys_ctrl_pkg::ADDR_CLOCK_SELECT
    |=> out_recovered_heartbeat_enable == $past(mgmt_wdata[2]) && out_free_heartbeat_enable == $past(mgmt_wdata[1]))
    else $error("heartbeat enable does not follow write");
  a_reset_values: assert property ($rose(resetn) |-> !out_recovered_125m_enable && !out_free_125m_enable
    && !out_reference_25m_enable && !state_reg.soft_reset)
    else $error("registers not zero after reset");
  a_boot_sample: assert property ($rose(resetn) |=> cfg_load && cfg_value == $past(cfg_pins))
    else $error("pins not sampled after reset release");
  a_self_clear: assert property ($rose(state_reg.soft_reset) |-> ##11 !state_reg.soft_reset [*1] or ##12
    !state_reg.soft_reset)
    else $error("soft reset bit did not clear in time");
  a_reset_hold: assert property ($fell(subsys_rst_n) |-> !subsys_rst_n [*8])
    else $error("subsystem reset released too early");

  c_resample: cover property (state_reg.st == subsys_ctrl_pkg::ST_SAMPLE);
  c_reload: cover property (state_reg.st == subsys_ctrl_pkg::ST_LOAD && !state_reg.resample_en);
  c_c22_access: cover property (mgmt_c22 && mgmt_rd && mgmt_reg_addr[4:0] == subsys_ctrl_pkg::C22_ADDR_DATA);
  c_clock_on: cover property (out_free_125m_enable);

endmodule : subsystem_reset_clock_out_ctrl

`default_nettype wire

/* File: mgmt_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// behavioural management host on the parallel side of the frame decoder
module mgmt_host_model (
  // clock
  input wire logic clk,
  // request side
  output logic c22,
  output logic [4:0] dev,
  output logic [15:0] addr,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata,
  // answer side
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  // idle bus at time zero
  initial
  begin
    c22 = 1'b0;
    dev = 5'h00;
    addr = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end

  // one strobe cycle; dev, addr and wdata are scrambled after release so stale values never help
  task automatic issue(input logic c, input logic [4:0] d, input logic [15:0] a, input logic [15:0] v,
                       input logic w);
    @(posedge clk);
    #1;
    c22 = c;
    dev = d;
    addr = a;
    wdata = v;
    wr = w;
    rd = ~w;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    addr = ~addr;
    wdata = ~wdata;
    dev = ~dev;
  endtask : issue

  // read: answer is due one cycle after the strobe, waited for under a bound
  task automatic read(input logic c, input logic [4:0] d, input logic [15:0] a, output logic [15:0] q,
                      output logic ok);
    int n;
    n = 0;
    issue(c, d, a, 16'h0000, 1'b0);
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    q = rdata;
    ok = (n == 0) && (rvalid === 1'b1);
  endtask : read
endmodule : mgmt_host_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the subsystem reset and aux clock select block
module testbench;
  // clock, reset and port nets
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] cfg_pins = 8'h5a;
  logic c22, wr, rd, rvalid, cfg_load, subsys_rst_n, en5, en4, en2, en1, en0;
  logic [4:0] dev;
  logic [15:0] addr, wdata, rdata;
  logic [7:0] cfg_value;
  wire logic [5:0] en_vec = {en5, en4, 1'b0, en2, en1, en0};
  int fail_count = 0;
  int checks_done = 0;
  localparam logic [4:0] MMD = subsys_ctrl_pkg::MMD_SUBSYSTEM;

  always #4 clk = ~clk;

  subsystem_reset_clock_out_ctrl #(.CFG_W(8)) i_subsystem_reset_clock_out_ctrl (.clk(clk), .resetn(resetn),
    .mgmt_c22(c22), .mgmt_dev_addr(dev), .mgmt_reg_addr(addr), .mgmt_wr(wr), .mgmt_rd(rd),
    .mgmt_wdata(wdata), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .cfg_pins(cfg_pins),
    .cfg_value(cfg_value), .cfg_load(cfg_load), .subsys_rst_n(subsys_rst_n),
    .out_recovered_125m_enable(en5), .out_free_125m_enable(en4), .out_recovered_heartbeat_enable(en2),
    .out_free_heartbeat_enable(en1), .out_reference_25m_enable(en0));

  mgmt_host_model i_mgmt_host_model (.clk(clk), .c22(c22), .dev(dev), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata), .rdata(rdata), .rvalid(rvalid));

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // single comparison point
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // read one register and compare, including the answer strobe
  task automatic rd_chk(input logic c, input logic [4:0] d, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic ok;
    i_mgmt_host_model.read(c, d, a, q, ok);
    check("rvalid", {15'h0000, ok}, 16'h0001);
    check($sformatf("reg %h", a), q, exp);
  endtask : rd_chk

  // reset values, boot capture of the pins and unmapped places
  task automatic test_reset();
    check("boot cfg_load", {15'h0000, cfg_load}, 16'h0001);
    check("boot cfg_value", {8'h00, cfg_value}, 16'h005a);
    rd_chk(1'b0, MMD, subsys_ctrl_pkg::ADDR_SOFT_RESET, 16'h0000);
    rd_chk(1'b0, MMD, subsys_ctrl_pkg::ADDR_RESAMPLE_EN, 16'h0000);
    rd_chk(1'b0, MMD, subsys_ctrl_pkg::ADDR_CLOCK_SELECT, 16'h0000);
    check("enables", {10'h000, en_vec}, 16'h0000);
    i_mgmt_host_model.issue(1'b0, MMD, 16'hff23, 16'h1234, 1'b1);
    rd_chk(1'b0, MMD, 16'hff23, 16'h0000);
    $display("test reset done");
  endtask : test_reset

  // every clock source alone, then reserved bits and a foreign device address
  task automatic test_clock_select();
    int b;
    for (b = 5; b >= 0; b--)
    begin
      if (b == 3)
        continue;
      i_mgmt_host_model.issue(1'b0, MMD, subsys_ctrl_pkg::ADDR_CLOCK_SELECT, 16'h0001 << b, 1'b1);
      check("enables", {10'h000, en_vec}, 16'h0001 << b);
      rd_chk(1'b0, MMD, subsys_ctrl_pkg::ADDR_CLOCK_SELECT, 16'h0001 << b);
    end
    i_mgmt_host_model.issue(1'b0, 5'h1d, subsys_ctrl_pkg::ADDR_CLOCK_SELECT, 16'h0020, 1'b1);
    check("foreign mmd write", {10'h000, en_vec}, 16'h0001);
    rd_chk(1'b0, 5'h1d, subsys_ctrl_pkg::ADDR_CLOCK_SELECT, 16'h0000);
    // reserved bits and bit 3 set, with only one clock source enabled
    i_mgmt_host_model.issue(1'b0, MMD, subsys_ctrl_pkg::ADDR_CLOCK_SELECT, 16'hffc9, 1'b1);
    check("enables", {10'h000, en_vec}, 16'h0001);
    rd_chk(1'b0, MMD, subsys_ctrl_pkg::ADDR_CLOCK_SELECT, 16'h0009);
    $display("test clock select done");
  endtask : test_clock_select

  // indirect access through pointer and data registers
  task automatic test_indirect();
    i_mgmt_host_model.issue(1'b1, 5'h00, 16'h0010, subsys_ctrl_pkg::ADDR_CLOCK_SELECT, 1'b1);
    rd_chk(1'b1, 5'h00, 16'h0010, subsys_ctrl_pkg::ADDR_CLOCK_SELECT);
    i_mgmt_host_model.issue(1'b1, 5'h00, 16'h0011, 16'h0002, 1'b1);
    check("indirect write", {10'h000, en_vec}, 16'h0002);
    rd_chk(1'b1, 5'h00, 16'h0011, 16'h0002);
    $display("test indirect done");
  endtask : test_indirect

  // soft reset: pins change beforehand, so reload and resample give different values
  task automatic test_soft(input logic resample, input logic [7:0] pins, input int low, input logic [7:0] exp);
    int n;
    n = 2; // the poll starts two cycles into the sequence, after the busy read
    i_mgmt_host_model.issue(1'b0, MMD, subsys_ctrl_pkg::ADDR_RESAMPLE_EN, {15'h0000, resample}, 1'b1);
    cfg_pins = pins;
    i_mgmt_host_model.issue(1'b0, MMD, subsys_ctrl_pkg::ADDR_SOFT_RESET, 16'h0001, 1'b1);
    rd_chk(1'b0, MMD, subsys_ctrl_pkg::ADDR_SOFT_RESET, 16'h0001);
    while (subsys_rst_n !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("reset low cycles", n[15:0], low[15:0]);
    if (n == 40)
      final_report();
    check("cfg_load", {15'h0000, cfg_load}, 16'h0001);
    check("cfg_value", {8'h00, cfg_value}, {8'h00, exp});
    rd_chk(1'b0, MMD, subsys_ctrl_pkg::ADDR_SOFT_RESET, 16'h0000);
    rd_chk(1'b0, MMD, subsys_ctrl_pkg::ADDR_CLOCK_SELECT, 16'h0002);
    $display("test soft reset %0d done", resample);
  endtask : test_soft

  // hang guard
  initial
  begin
    #200000;
    fail_count++;
    final_report();
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    @(posedge clk);
    #1;
    test_reset();
    test_clock_select();
    test_indirect();
    test_soft(1'b0, 8'ha3, 11, 8'h5a);
    test_soft(1'b1, 8'hc6, 12, 8'hc6);
    final_report();
  end
endmodule : testbench
`default_nettype wire
